// ### core/sior_irq_pol.sv
`timescale 1ns/10ps
`default_nettype none
// Polarity stage for one interrupt line
module sior_irq_pol (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control and request
	input wire logic active_high,
	input wire logic req,
	// Pin
	output logic pin_out,
	output logic pin_oe
);
	// Low idle driven when active high, tri-state idle when active low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= active_high ? req : 1'b0;
			pin_oe <= active_high ? 1'b1 : req;
		end
	end
endmodule // sior_irq_pol
`default_nettype wire

// ### core/sior_pkg.sv
package sior_pkg;

	// ----------------------------------------
	// Host I/O ports and register indexes
	// ----------------------------------------
	localparam logic [9:0] INDEX_PORT = 10'h3_F0;
	localparam logic [9:0] DATA_PORT = 10'h3_F1;
	localparam logic [7:0] IDX_PRINTER = 8'h01;
	localparam logic [7:0] IDX_SERIAL = 8'h02;
	localparam logic [7:0] IDX_FLOPPY = 8'h03;

	// ----------------------------------------
	// Power-up values and floppy reserved-bit mask
	// ----------------------------------------
	localparam logic [7:0] RST_PRINTER = 8'h9F;
	localparam logic [7:0] RST_SERIAL = 8'hDC;
	localparam logic [7:0] RST_FLOPPY = 8'h78;
	localparam logic [7:0] FLOPPY_RSVD_MASK = 8'hFA;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PP_PWR_BIT = 2;
	localparam int PP_MODE_BIT = 3;
	localparam int IRQ_POL_BIT = 4;
	localparam int LOCK_BIT = 7;
	localparam int SP1_EN_BIT = 2;
	localparam int SP1_PWR_BIT = 3;
	localparam int SP2_EN_BIT = 6;
	localparam int SP2_PWR_BIT = 7;
	localparam int OS_TWO_BIT = 1;
	localparam int ADR_SEL_BIT = 7;

	// ----------------------------------------
	// Base addresses
	// ----------------------------------------
	localparam logic [9:0] PP_BASE_1 = 10'h3_BC;
	localparam logic [9:0] PP_BASE_2 = 10'h3_78;
	localparam logic [9:0] PP_BASE_3 = 10'h2_78;
	localparam logic [9:0] COM1_BASE = 10'h3_F8;
	localparam logic [9:0] COM2_BASE = 10'h2_F8;
	localparam logic [9:0] C34_0_A = 10'h3_38;
	localparam logic [9:0] C34_0_B = 10'h2_38;
	localparam logic [9:0] C34_1_A = 10'h3_E8;
	localparam logic [9:0] C34_1_B = 10'h2_E8;
	localparam logic [9:0] C34_2_A = 10'h2_E8;
	localparam logic [9:0] C34_2_B = 10'h2_E0;
	localparam logic [9:0] C34_3_A = 10'h2_20;
	localparam logic [9:0] C34_3_B = 10'h2_28;

	// Floppy interface modes
	typedef enum logic [1:0] {
		SIOR_FMODE_B = 2'b00,
		SIOR_FMODE_A = 2'b01,
		SIOR_FMODE_RSVD = 2'b10,
		SIOR_FMODE_AT = 2'b11
	} sior_fmode_t;

	// Host I/O cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] addr;
		logic [7:0] data;
	} sior_io_t;

	// Decoded resource controls
	typedef struct packed {
		logic pp_active;
		logic [9:0] pp_base;
		logic pp_powered;
		logic pp_printer_mode;
		logic irq_active_high;
		logic sp1_active;
		logic [9:0] sp1_base;
		logic sp1_powered;
		logic sp2_active;
		logic [9:0] sp2_base;
		logic sp2_powered;
		logic floppy_enhanced;
		logic [1:0] drive_opt;
		sior_fmode_t floppy_mode;
		logic adr_out_sel;
	} sior_ctrl_t;

endpackage

// ### core/sior_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Configuration register bank
// ----------------------------------------
module sior_regs (
	// Clock and resets
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic power_on_rst,
	input wire logic hard_rst,
	// Host I/O
	input wire logic config_mode,
	input wire sior_pkg::sior_io_t io,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// Decode of host cycles
	output logic pp_hit,
	output logic sp1_hit,
	output logic sp2_hit,
	// Resource controls
	output sior_pkg::sior_ctrl_t ctrl,
	// Floppy rate select
	input wire logic [1:0] rate_sel,
	output logic rate_select_out0,
	output logic rate_select_out1,
	// Shared address/drive-2 pin
	input wire logic second_drive_indicator,
	input wire logic decoded_addr_hit,
	output logic decoded_addr_out,
	output logic decoded_addr_oe,
	output logic drive2_present,
	// Interrupt requests and pins
	input wire logic [3:0] irq_req,
	output logic serial_irq_a,
	output logic serial_irq_a_oe,
	output logic serial_irq_b,
	output logic serial_irq_b_oe,
	output logic floppy_irq_out,
	output logic floppy_irq_out_oe,
	output logic printer_irq_out,
	output logic printer_irq_out_oe
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] config_index_reg;
	logic [7:0] printer_port_setup;
	logic [7:0] serial_port_setup;
	logic [7:0] floppy_option_setup;
	logic second_drive_indicator_meta;
	logic second_drive_indicator_sync;
	logic [1:0] rate_sel_q;
	logic [3:0] irq_pin_out;
	logic [3:0] irq_pin_oe;

	// ----------------------------------------
	// Host cycle decode
	// ----------------------------------------
	wire logic config_lock_bit = printer_port_setup[sior_pkg::LOCK_BIT];
	wire logic idx_wr = config_mode && io.wr && io.addr == sior_pkg::INDEX_PORT;
	wire logic data_cyc = config_mode && io.addr == sior_pkg::DATA_PORT;
	// Lock cleared shuts data port for reads and writes
	wire logic data_ok = data_cyc && config_lock_bit;
	wire logic data_wr = data_ok && io.wr;
	wire logic data_rd = data_ok && io.rd;
	wire logic wr_pp = data_wr && config_index_reg == sior_pkg::IDX_PRINTER;
	wire logic wr_sp = data_wr && config_index_reg == sior_pkg::IDX_SERIAL;
	wire logic wr_fo = data_wr && config_index_reg == sior_pkg::IDX_FLOPPY;
	// Lock may only go from 1 to 0 by software
	wire logic next_lock = config_lock_bit & io.data[sior_pkg::LOCK_BIT];

	// Read mux, unknown index reads zero
	wire logic [7:0] next_rd_data =
		(config_index_reg == sior_pkg::IDX_PRINTER) ? printer_port_setup :
		(config_index_reg == sior_pkg::IDX_SERIAL) ? serial_port_setup :
		(config_index_reg == sior_pkg::IDX_FLOPPY) ? (floppy_option_setup & sior_pkg::FLOPPY_RSVD_MASK) :
		8'h00;

	// ----------------------------------------
	// Index register and host read path
	// ----------------------------------------
	// Ordinary reset leaves configuration alone, so it only clears the read data and strobe
	always_ff @(posedge clk) begin
		if (power_on_rst) begin
			config_index_reg <= 8'h00;
		end else if (idx_wr) begin
			config_index_reg <= io.data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || power_on_rst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_data <= data_rd ? next_rd_data : 8'h00;
			rd_valid <= data_rd;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Only power-up restores defaults; sys_rst deliberately absent
	always_ff @(posedge clk) begin
		if (power_on_rst) begin
			printer_port_setup <= sior_pkg::RST_PRINTER;
		end else if (wr_pp) begin
			printer_port_setup <= {next_lock, io.data[6:0]};
		end else if (hard_rst) begin
			printer_port_setup[sior_pkg::LOCK_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (power_on_rst) begin
			serial_port_setup <= sior_pkg::RST_SERIAL;
		end else if (wr_sp) begin
			serial_port_setup <= io.data;
		end
	end

	always_ff @(posedge clk) begin
		if (power_on_rst) begin
			floppy_option_setup <= sior_pkg::RST_FLOPPY;
		end else if (wr_fo) begin
			floppy_option_setup <= io.data & sior_pkg::FLOPPY_RSVD_MASK;
		end
	end

	// ----------------------------------------
	// Base address decode
	// ----------------------------------------
	wire logic [9:0] pp_table [4];
	assign pp_table[0] = 10'h0_00;
	assign pp_table[1] = sior_pkg::PP_BASE_1;
	assign pp_table[2] = sior_pkg::PP_BASE_2;
	assign pp_table[3] = sior_pkg::PP_BASE_3;
	wire logic [9:0] pp_base = pp_table[printer_port_setup[1:0]];
	wire logic pp_on = printer_port_setup[1:0] != 2'b00;

	wire logic [9:0] c34_a [4];
	wire logic [9:0] c34_b [4];
	assign c34_a[0] = sior_pkg::C34_0_A;
	assign c34_b[0] = sior_pkg::C34_0_B;
	assign c34_a[1] = sior_pkg::C34_1_A;
	assign c34_b[1] = sior_pkg::C34_1_B;
	assign c34_a[2] = sior_pkg::C34_2_A;
	assign c34_b[2] = sior_pkg::C34_2_B;
	assign c34_a[3] = sior_pkg::C34_3_A;
	assign c34_b[3] = sior_pkg::C34_3_B;
	wire logic [9:0] third_base = c34_a[printer_port_setup[6:5]];
	wire logic [9:0] fourth_base = c34_b[printer_port_setup[6:5]];

	wire logic [9:0] sp1_base;
	wire logic [9:0] sp2_base;
	sior_sel u_sel1 (
		.code(serial_port_setup[1:0]),
		.third_base(third_base),
		.fourth_base(fourth_base),
		.base(sp1_base)
	);
	sior_sel u_sel2 (
		.code(serial_port_setup[5:4]),
		.third_base(third_base),
		.fourth_base(fourth_base),
		.base(sp2_base)
	);

	wire logic sp1_on = serial_port_setup[sior_pkg::SP1_EN_BIT];
	wire logic sp2_on = serial_port_setup[sior_pkg::SP2_EN_BIT];
	wire logic host_cyc = io.rd || io.wr;
	// Eight-byte windows; disabled ports never claim a cycle
	wire logic pp_match = pp_on && host_cyc && io.addr[9:3] == pp_base[9:3];
	wire logic sp1_match = sp1_on && host_cyc && io.addr[9:3] == sp1_base[9:3];
	wire logic sp2_match = sp2_on && host_cyc && io.addr[9:3] == sp2_base[9:3];

	// ----------------------------------------
	// Floppy controls
	// ----------------------------------------
	wire logic os_two = floppy_option_setup[sior_pkg::OS_TWO_BIT];
	// Drive options only matter outside enhanced mode two
	wire logic [1:0] eff_opt = os_two ? 2'b11 : floppy_option_setup[4:3];
	// Option 11 passes rate select straight; 10 swaps, 01 forces low bit, 00 forces high bit
	wire logic [1:0] next_rate =
		(eff_opt == 2'b11) ? rate_sel :
		(eff_opt == 2'b10) ? {rate_sel[0], rate_sel[1]} :
		(eff_opt == 2'b01) ? {rate_sel[1], 1'b0} :
		{1'b0, rate_sel[0]};
	wire logic adr_sel = floppy_option_setup[sior_pkg::ADR_SEL_BIT];

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pp_hit <= 1'b0;
			sp1_hit <= 1'b0;
			sp2_hit <= 1'b0;
			rate_sel_q <= 2'b00;
		end else begin
			pp_hit <= pp_match;
			sp1_hit <= sp1_match;
			sp2_hit <= sp2_match;
			rate_sel_q <= next_rate;
		end
	end

	assign rate_select_out0 = rate_sel_q[0];
	assign rate_select_out1 = rate_sel_q[1];

	// Control bundle follows the registers one edge later
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= '0;
		end else begin
			ctrl.pp_active <= pp_on;
			ctrl.pp_base <= pp_base;
			ctrl.pp_powered <= printer_port_setup[sior_pkg::PP_PWR_BIT];
			ctrl.pp_printer_mode <= printer_port_setup[sior_pkg::PP_MODE_BIT];
			ctrl.irq_active_high <= printer_port_setup[sior_pkg::IRQ_POL_BIT];
			ctrl.sp1_active <= sp1_on;
			ctrl.sp1_base <= sp1_base;
			ctrl.sp1_powered <= serial_port_setup[sior_pkg::SP1_PWR_BIT];
			ctrl.sp2_active <= sp2_on;
			ctrl.sp2_base <= sp2_base;
			ctrl.sp2_powered <= serial_port_setup[sior_pkg::SP2_PWR_BIT];
			ctrl.floppy_enhanced <= os_two;
			ctrl.drive_opt <= eff_opt;
			ctrl.floppy_mode <= sior_pkg::sior_fmode_t'(floppy_option_setup[6:5]);
			ctrl.adr_out_sel <= adr_sel;
		end
	end

	// ----------------------------------------
	// Shared address/drive-2 pin
	// ----------------------------------------
	// Pin input is asynchronous, two stages before use
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			second_drive_indicator_meta <= 1'b0;
			second_drive_indicator_sync <= 1'b0;
			drive2_present <= 1'b0;
			decoded_addr_out <= 1'b0;
			decoded_addr_oe <= 1'b0;
		end else begin
			second_drive_indicator_meta <= second_drive_indicator;
			second_drive_indicator_sync <= second_drive_indicator_meta;
			drive2_present <= adr_sel ? 1'b0 : second_drive_indicator_sync;
			decoded_addr_out <= adr_sel && decoded_addr_hit;
			decoded_addr_oe <= adr_sel;
		end
	end

	// ----------------------------------------
	// Interrupt pins
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_irq
			sior_irq_pol u_pol (
				.clk(clk),
				.sys_rst(sys_rst),
				.active_high(printer_port_setup[sior_pkg::IRQ_POL_BIT]),
				.req(irq_req[gi]),
				.pin_out(irq_pin_out[gi]),
				.pin_oe(irq_pin_oe[gi])
			);
		end
	endgenerate

	assign serial_irq_a = irq_pin_out[0];
	assign serial_irq_a_oe = irq_pin_oe[0];
	assign serial_irq_b = irq_pin_out[1];
	assign serial_irq_b_oe = irq_pin_oe[1];
	assign floppy_irq_out = irq_pin_out[2];
	assign floppy_irq_out_oe = irq_pin_oe[2];
	assign printer_irq_out = irq_pin_out[3];
	assign printer_irq_out_oe = irq_pin_oe[3];

endmodule // sior_regs
`default_nettype wire

// ### core/sior_sel.sv
`timescale 1ns/10ps
`default_nettype none
// Chooses a serial base from a two-bit code
module sior_sel (
	// Selection
	input wire logic [1:0] code,
	input wire logic [9:0] third_base,
	input wire logic [9:0] fourth_base,
	// Result
	output logic [9:0] base
);
	wire logic [9:0] pick [4];
	assign pick[0] = sior_pkg::COM1_BASE;
	assign pick[1] = sior_pkg::COM2_BASE;
	assign pick[2] = third_base;
	assign pick[3] = fourth_base;
	// Same code map for both ports
	assign base = pick[code];
endmodule // sior_sel
`default_nettype wire

// ### tb/sior_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor on the configuration I/O bus
module sior_host_model (
	// Clock
	input wire logic clk,
	// Answer
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	// Host cycle
	output var sior_pkg::sior_io_t io
);
	initial begin
		io = '0;
	end
	// One strobe for one edge; released bus shows the inverse so stale values never match
	task automatic cycle(input logic wr, input logic [9:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic got);
		@(posedge clk);
		io <= '{wr: wr, rd: !wr, addr: a, data: d};
		@(posedge clk);
		io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
		#1;
		q = rd_data;
		got = rd_valid;
	endtask
endmodule // sior_host_model
`default_nettype wire

// ### tb/sior_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the configuration register bank
module sior_regs_chk (
	// Clock and resets
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic power_on_rst,
	// Host side
	input wire logic config_mode,
	input wire sior_pkg::sior_io_t io,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic pp_hit,
	// Controls and pins
	input wire sior_pkg::sior_ctrl_t ctrl,
	input wire logic [1:0] rate_sel,
	input wire logic rate_select_out0,
	input wire logic decoded_addr_oe,
	input wire logic [3:0] irq_req,
	input wire logic serial_irq_a,
	input wire logic serial_irq_a_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || power_on_rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Control held two edges, clear of reset, so outputs one edge back are settled
	sequence s_steady(b);
		b && $past(b) && !$past(sys_rst) && !$past(sys_rst, 2);
	endsequence
	sequence s_rd_taken;
		$past(config_mode && io.rd && io.addr == sior_pkg::DATA_PORT);
	endsequence
	sequence s_rd_refused;
		!config_mode && io.rd;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rd_cause;
		rd_valid |-> s_rd_taken;
	endproperty
	property p_rd_refuse;
		s_rd_refused |=> !rd_valid;
	endproperty
	property p_rd_zero;
		!rd_valid |-> rd_data == 8'h00;
	endproperty
	property p_irq_high;
		s_steady(ctrl.irq_active_high) |-> $past(serial_irq_a_oe) && $past(serial_irq_a) == $past(irq_req[0], 2);
	endproperty
	property p_irq_low;
		s_steady(!ctrl.irq_active_high) |-> !$past(serial_irq_a) && $past(serial_irq_a_oe) == $past(irq_req[0], 2);
	endproperty
	property p_rate_pass;
		s_steady(ctrl.floppy_enhanced) |-> $past(rate_select_out0) == $past(rate_sel[0], 2);
	endproperty
	property p_adr_oe;
		s_steady(ctrl.adr_out_sel) |-> $past(decoded_addr_oe);
	endproperty
	property p_pp_off;
		s_steady(!ctrl.pp_active) |-> !$past(pp_hit);
	endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("read answer without a read");
	a_rd_refuse: assert property (p_rd_refuse) else $error("read answered outside config mode");
	a_rd_zero: assert property (p_rd_zero) else $error("read data not zero when idle");
	a_irq_high: assert property (p_irq_high) else $error("high polarity pin wrong");
	a_irq_low: assert property (p_irq_low) else $error("low polarity pin wrong");
	a_rate_pass: assert property (p_rate_pass) else $error("drive options not ignored");
	a_adr_oe: assert property (p_adr_oe) else $error("address output not enabled");
	a_pp_off: assert property (p_pp_off) else $error("disabled printer port decoded");
endmodule // sior_regs_chk

bind sior_regs sior_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .power_on_rst(power_on_rst),
	.config_mode(config_mode), .io(io), .rd_data(rd_data), .rd_valid(rd_valid), .pp_hit(pp_hit),
	.ctrl(ctrl), .rate_sel(rate_sel), .rate_select_out0(rate_select_out0), .decoded_addr_oe(decoded_addr_oe),
	.irq_req(irq_req), .serial_irq_a(serial_irq_a), .serial_irq_a_oe(serial_irq_a_oe));
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the configuration register bank
module testbench;
	logic clk, sys_rst, power_on_rst, hard_rst, config_mode, second_drive_indicator_in, addr_hit;
	logic rd_valid, got, pp_hit, sp1_hit, sp2_hit, ro0, ro1, adr_oe, adr_out, second_drive_indicator_p;
	logic [1:0] rate_sel;
	logic [3:0] irq_req, irq_p, irq_e;
	logic [7:0] rd_data, q;
	sior_pkg::sior_io_t io;
	sior_pkg::sior_ctrl_t ctrl;
	int failures, compares;
	logic [9:0] pp_tab [4] = '{sior_pkg::PP_BASE_3, sior_pkg::PP_BASE_1, sior_pkg::PP_BASE_2, sior_pkg::PP_BASE_3};
	logic [9:0] ca_tab [4] = '{sior_pkg::C34_0_A, sior_pkg::C34_1_A, sior_pkg::C34_2_A, sior_pkg::C34_3_A};
	logic [9:0] cb_tab [4] = '{sior_pkg::C34_0_B, sior_pkg::C34_1_B, sior_pkg::C34_2_B, sior_pkg::C34_3_B};

	sior_regs dut (.clk(clk), .sys_rst(sys_rst), .power_on_rst(power_on_rst), .hard_rst(hard_rst),
		.config_mode(config_mode), .io(io), .rd_data(rd_data), .rd_valid(rd_valid), .pp_hit(pp_hit),
		.sp1_hit(sp1_hit), .sp2_hit(sp2_hit), .ctrl(ctrl), .rate_sel(rate_sel), .rate_select_out0(ro0),
		.rate_select_out1(ro1), .second_drive_indicator(second_drive_indicator_in), .decoded_addr_hit(addr_hit),
		.decoded_addr_out(adr_out), .decoded_addr_oe(adr_oe), .drive2_present(second_drive_indicator_p), .irq_req(irq_req),
		.serial_irq_a(irq_p[0]), .serial_irq_a_oe(irq_e[0]), .serial_irq_b(irq_p[1]), .serial_irq_b_oe(irq_e[1]),
		.floppy_irq_out(irq_p[2]), .floppy_irq_out_oe(irq_e[2]), .printer_irq_out(irq_p[3]),
		.printer_irq_out_oe(irq_e[3]));
	sior_host_model host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .io(io));

	// ----------------------------------------
	// Clock, watchdog and shared tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// The whole sequence needs well under a thousand cycles
	initial begin
		#(25 * 5000);
		failures++;
		give_verdict();
	end
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [9:0] v, input logic [9:0] e);
		compares++;
		if (v !== e) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, v, e);
		end
	endtask
	// Index first, then data; two edges let the controls settle
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
		host.cycle(1'b1, sior_pkg::INDEX_PORT, idx, q, got);
		host.cycle(1'b1, sior_pkg::DATA_PORT, val, q, got);
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Expected value carries the answer flag above the byte
	task automatic rd_reg(input logic [7:0] idx, input logic [9:0] e);
		host.cycle(1'b1, sior_pkg::INDEX_PORT, idx, q, got);
		host.cycle(1'b0, sior_pkg::DATA_PORT, 8'h00, q, got);
		chk({1'b0, got, q}, e);
	endtask
	task automatic step();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		power_on_rst = 1'b1;
		{hard_rst, config_mode, second_drive_indicator_in, addr_hit, rate_sel, irq_req} = '0;
		failures = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		{sys_rst, power_on_rst} <= 2'b00;
		config_mode <= 1'b1;
		rd_reg(sior_pkg::IDX_PRINTER, 10'h19F);
		rd_reg(sior_pkg::IDX_SERIAL, 10'h1DC);
		rd_reg(sior_pkg::IDX_FLOPPY, 10'h178);
		chk(ctrl.sp1_base, sior_pkg::COM1_BASE);
		chk(ctrl.sp2_base, sior_pkg::COM2_BASE);
		chk({ctrl.floppy_mode, ctrl.drive_opt}, 4'hF);
		// Every printer base code, with a host cycle at that base
		for (int i = 0; i < 4; i++) begin
			wr_reg(sior_pkg::IDX_PRINTER, 8'h9C | 8'(i));
			chk(ctrl.pp_active ? ctrl.pp_base : 10'h000, i != 0 ? pp_tab[i] : 10'h000);
			host.cycle(1'b0, pp_tab[i], 8'h00, q, got);
			chk(pp_hit, i != 0);
		end
		// Primary on the third base, secondary on the fourth, for every pair
		wr_reg(sior_pkg::IDX_SERIAL, 8'hFE);
		chk({ctrl.sp1_active, ctrl.sp1_powered, ctrl.sp2_active, ctrl.sp2_powered}, 4'hF);
		for (int c = 0; c < 4; c++) begin
			wr_reg(sior_pkg::IDX_PRINTER, 8'h9F | 8'(c << 5));
			chk(ctrl.sp1_base, ca_tab[c]);
			chk(ctrl.sp2_base, cb_tab[c]);
			host.cycle(1'b0, ca_tab[c], 8'h00, q, got);
			chk(sp1_hit, 1'b1);
			host.cycle(1'b0, cb_tab[c], 8'h00, q, got);
			chk(sp2_hit, 1'b1);
		end
		wr_reg(sior_pkg::IDX_SERIAL, 8'h02);
		chk({ctrl.sp1_active, ctrl.sp1_powered, ctrl.sp2_active, ctrl.sp2_powered}, 4'h0);
		host.cycle(1'b0, ca_tab[3], 8'h00, q, got);
		chk(sp1_hit, 1'b0);
		wr_reg(sior_pkg::IDX_PRINTER, 8'h93);
		chk({ctrl.pp_powered, ctrl.pp_printer_mode}, 2'b00);
		// Floppy options: reserved bits, enhanced mode, drive options, modes
		wr_reg(sior_pkg::IDX_FLOPPY, 8'hFF);
		rd_reg(sior_pkg::IDX_FLOPPY, 10'h1FA);
		chk({ctrl.floppy_enhanced, adr_oe}, 2'b11);
		// Pins change on an edge; the drive-2 pin needs three edges to show
		@(posedge clk);
		rate_sel <= 2'b10;
		addr_hit <= 1'b1;
		second_drive_indicator_in <= 1'b1;
		step();
		chk({ro1, ro0, adr_out, second_drive_indicator_p}, 4'b1010);
		wr_reg(sior_pkg::IDX_FLOPPY, 8'h70);
		chk({ro1, ro0, adr_oe, adr_out, second_drive_indicator_p}, 5'b01001);
		// Both rate bits high, so the two forcing options show apart
		@(posedge clk);
		rate_sel <= 2'b11;
		wr_reg(sior_pkg::IDX_FLOPPY, 8'h68);
		chk({ro1, ro0}, 2'b10);
		wr_reg(sior_pkg::IDX_FLOPPY, 8'h60);
		chk({ro1, ro0}, 2'b01);
		for (int m = 0; m < 4; m++) begin
			wr_reg(sior_pkg::IDX_FLOPPY, 8'(m << 5));
			chk(ctrl.floppy_mode, 10'(m));
		end
		// Interrupt pins in both polarities
		@(posedge clk);
		irq_req <= 4'b0101;
		step();
		chk({irq_p, irq_e}, 8'h5F);
		wr_reg(sior_pkg::IDX_PRINTER, 8'h83);
		chk({irq_p, irq_e}, 8'h05);
		// Ordinary reset keeps contents; no access outside config mode
		@(posedge clk);
		irq_req <= 4'h0;
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rd_reg(sior_pkg::IDX_PRINTER, 10'h183);
		@(posedge clk);
		config_mode <= 1'b0;
		rd_reg(sior_pkg::IDX_SERIAL, 10'h000);
		// Lock: once cleared only a hard or power-up reset sets it again
		@(posedge clk);
		config_mode <= 1'b1;
		wr_reg(sior_pkg::IDX_PRINTER, 8'h1F);
		rd_reg(sior_pkg::IDX_PRINTER, 10'h000);
		wr_reg(sior_pkg::IDX_PRINTER, 8'h9F);
		rd_reg(sior_pkg::IDX_SERIAL, 10'h000);
		@(posedge clk);
		hard_rst <= 1'b1;
		@(posedge clk);
		hard_rst <= 1'b0;
		rd_reg(sior_pkg::IDX_PRINTER, 10'h19F);
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
